// [common/lpd_pkg.sv]
// Constants and helper functions shared by the LED PWM driver files.
package lpd_pkg;

    // System clock rate in hertz.
    localparam int unsigned CLK_HZ = 10_000_000;
    // Fastest repetition rate in hertz and slots per repetition period.
    localparam int unsigned BASE_RATE_HZ = 256;
    localparam int unsigned SLOTS = 32;
    // Clock cycles per slot at the fastest rate, rounded down.
    localparam int unsigned SLOT_CYCLES = CLK_HZ / (BASE_RATE_HZ * SLOTS);
    // Ramp step rate in hertz (one step every 1/64 s).
    localparam int unsigned RAMP_STEP_HZ = 64;
    // Clock cycles per ramp step, rounded down.
    localparam int unsigned RAMP_STEP_CYCLES = CLK_HZ / RAMP_STEP_HZ;

    // APB address width and register byte offsets.
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_RED = 12'h004;
    localparam logic [11:0] ADDR_GREEN = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;

    // Control register bit positions.
    localparam int unsigned CTRL_OVRD_BIT = 0;
    localparam int unsigned CTRL_THERMAL_PERMIT_BIT = 1;
    // Channel register field positions.
    localparam int unsigned CFG_DUTY_LSB = 0;
    localparam int unsigned CFG_LEVEL_LSB = 6;
    localparam int unsigned CFG_RATE_LSB = 8;
    localparam int unsigned CFG_RAMP_BIT = 10;
    localparam int unsigned CFG_EN_BIT = 11;
    localparam int unsigned CFG_W = 12;
    // Status register field positions.
    localparam int unsigned STAT_GREEN_LSB = 8;
    localparam int unsigned STAT_SINK_LSB = 16;

    // Reset values: level 7.0 mA code, duty off, rate 256 Hz, all bits off.
    localparam logic [1:0] LEVEL_RST = 2'h1;
    localparam logic [11:0] CFG_RST = 12'h040;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Repetition rate codes and the full-on effective duty.
    localparam logic [1:0] RATE_256 = 2'h0;
    localparam logic [1:0] RATE_8 = 2'h1;
    localparam logic [1:0] RATE_1 = 2'h2;
    localparam logic [5:0] DUTY_FULL = 6'h20;

    // Maps a duty setting to an effective duty of 0 to 32 slots.
    function automatic logic [5:0] lpd_duty_target(input logic [5:0] dc);
        lpd_duty_target = dc[5] ? DUTY_FULL : {1'b0, dc[4:0]};
    endfunction

    // Returns base slot ticks per slot, minus one, for a rate code.
    function automatic logic [9:0] lpd_rate_div(input logic [1:0] rate);
        case (rate)
            RATE_256: lpd_rate_div = 10'h000;
            RATE_8: lpd_rate_div = 10'h01F;
            RATE_1: lpd_rate_div = 10'h0FF;
            default: lpd_rate_div = 10'h1FF;
        endcase
    endfunction

endpackage

// [common/lpd_chan_if.sv]
// Settings and status that pass between the register file and one LED channel.
`timescale 1ns/1ns
interface lpd_chan_if;
    logic en;          // Channel enable.
    logic gate;        // Override and thermal permit both set.
    logic ramp_en;     // Ramp enable.
    logic [1:0] rate;  // Repetition rate code.
    logic [5:0] duty;  // Programmed duty setting.
    logic base_tick;   // One pulse per slot at the fastest rate.
    logic ramp_tick;   // One pulse per ramp step.
    logic [5:0] eff;   // Effective duty in slots.
    logic sink;        // Sink drive.
    modport cfg (output en, gate, ramp_en, rate, duty, base_tick, ramp_tick,
        input eff, sink);
    modport chan (input en, gate, ramp_en, rate, duty, base_tick, ramp_tick,
        output eff, sink);
endinterface // lpd_chan_if

// [verilog/lpd_led_channel.sv]
// One LED sink channel: duty ramping, slot timing and PWM output.
`timescale 1ns/1ns
module lpd_led_channel (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    lpd_chan_if.chan ch
);
    import lpd_pkg::*;

    logic [5:0] eff_q, eff_d;   // Effective duty.
    logic [4:0] slot_q;         // Slot within the period.
    logic [9:0] sub_q;          // Base ticks within the slot.
    logic sink_q;               // Registered sink drive.
    logic [5:0] target;         // Duty that the channel heads for.
    logic ramp_act;             // Ramping applies.
    logic slot_end;             // Last base tick of a slot.
    logic sink_d;               // Next sink drive.

    assign target = lpd_duty_target(ch.duty);
    assign ramp_act = ch.ramp_en && (ch.rate == RATE_256);
    // Greater-or-equal ends the slot at once when a faster rate is written mid-slot.
    // An exact match would let the sub-slot counter run on to its wrap and freeze the PWM.
    assign slot_end = ch.base_tick && (sub_q >= lpd_rate_div(ch.rate));
    // Direct apply without ramp, else one step per tick toward target.
    assign eff_d = !ramp_act ? target :
        (!ch.ramp_tick || eff_q == target) ? eff_q :
        (eff_q < target) ? eff_q + 6'h01 : eff_q - 6'h01;
    // On for eff slots of 32; all gates and nonzero duty needed.
    assign sink_d = ch.en && ch.gate && (ch.duty != 6'h00) &&
        ({1'b0, slot_q} < eff_q);

    // Effective duty register.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            eff_q <= 6'h00;
        end else begin
            eff_q <= eff_d;
        end
    end

    // Slot counters, stretched per slot by the rate divider.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sub_q <= 10'h000;
            slot_q <= 5'h00;
        end else if (slot_end) begin
            sub_q <= 10'h000;
            slot_q <= slot_q + 5'h01;
        end else if (ch.base_tick) begin
            sub_q <= sub_q + 10'h001;
        end
    end

    // Sink output register.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sink_q <= 1'b0;
        end else begin
            sink_q <= sink_d;
        end
    end

    assign ch.eff = eff_q;
    assign ch.sink = sink_q;

    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // Named step of the ramp.
    sequence s_ramp_step;
        ramp_act && ch.ramp_tick && (eff_q != target);
    endsequence

    AST_GATED_OFF: assert property (!(ch.en && ch.gate) |=> !sink_q)
        else $error("Sink driven while gated off.");
    AST_FULL_ON: assert property ((eff_q == DUTY_FULL) && ch.en && ch.gate
        && (ch.duty != 6'h00) |=> sink_q)
        else $error("Full duty did not keep the sink on.");
    AST_DIRECT: assert property (!ramp_act |=> eff_q == $past(target))
        else $error("Duty not applied at once without ramp.");
    AST_STEP: assert property (s_ramp_step |=>
        (eff_q == $past(eff_q) + 6'h01) || (eff_q == $past(eff_q) - 6'h01))
        else $error("Ramp step was not one slot.");
    AST_HOLD: assert property (ramp_act && !ch.ramp_tick |=> $stable(eff_q))
        else $error("Duty moved between ramp steps.");
    AST_STOP: assert property (ramp_act && (eff_q == target) |=> $stable(eff_q))
        else $error("Ramp went past its target.");
    AST_SLOT: assert property (slot_end |=> slot_q == $past(slot_q) + 5'h01)
        else $error("Slot did not advance at slot end.");
    AST_ZERO_OFF: assert property ((eff_q == 6'h00) |=> !sink_q)
        else $error("Sink on with zero effective duty.");

endmodule // lpd_led_channel

// [verilog/lpd_led_driver.sv]
// Two-channel LED PWM driver with ramp and blink, with an APB register file.
//
// Behaviour
// - Sink on needs enable, override, thermal, duty.
// - Red and green settings are independent; override and thermal gate both.
// - Two-bit level selects 3.5/7/10/12 mA, reset 7.
// - Duty zero off, 1-31 slots, top bit full.
// - Ramping only with ramp enable at 256 Hz.
// - Ramp moves one slot every 1/64 second.
// - Each new duty write starts a ramp; here only with ramp enable at 256 Hz, else it applies at once.
// - Without ramp enable, new duty applies at once.
// - Period code sets 256/8/1/0.5 Hz repetition.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
module lpd_led_driver #(
    parameter int unsigned RAMP_CYCLES = lpd_pkg::RAMP_STEP_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [lpd_pkg::ADDR_W-1:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic red_led_sink_out,
    output logic green_led_sink_out,
    output logic [1:0] red_led_current_level_out,
    output logic [1:0] green_led_current_level_out
);
    import lpd_pkg::*;

    // Counter widths for the two time bases.
    localparam int unsigned BW = $clog2(SLOT_CYCLES + 1);
    localparam int unsigned RW = $clog2(RAMP_CYCLES + 1);

    logic [1:0] ctrl_q;              // Override and thermal permit bits.
    logic [CFG_W-1:0] cfg_q [2];     // Channel settings, index 0 red, 1 green.
    logic [31:0] prdata_q;           // Registered read data.
    logic [BW-1:0] base_cnt_q;       // Slot time base counter.
    logic [RW-1:0] ramp_cnt_q;       // Ramp step time base counter.
    logic base_tick;                 // Slot time base pulse.
    logic ramp_tick;                 // Ramp step pulse.
    logic wr_acc;                    // Write access phase.
    logic rd_setup;                  // Read setup phase.
    logic sel_ctrl;                  // Control register addressed.
    logic sel_red;                   // Red settings addressed.
    logic sel_green;                 // Green settings addressed.
    logic sel_status;                // Status register addressed.
    logic mapped;                    // Any register addressed.
    logic [31:0] rd_d;               // Read data mux.
    logic [31:0] status_word;        // Live status word.
    logic [5:0] eff [2];             // Effective duties from channels.
    logic sink [2];                  // Sink drives from channels.

    lpd_chan_if ch_if [2] ();

    // Address decode and access phases.
    assign sel_ctrl = (paddr_in == ADDR_CTRL);
    assign sel_red = (paddr_in == ADDR_RED);
    assign sel_green = (paddr_in == ADDR_GREEN);
    assign sel_status = (paddr_in == ADDR_STATUS);
    assign mapped = sel_ctrl || sel_red || sel_green || sel_status;
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign rd_setup = psel_in && !penable_in && !pwrite_in;

    // Zero wait states; an unmapped address answers with an error.
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    // Status shows effective duties and live sink states.
    assign status_word = {14'h0000, sink[1], sink[0], 2'h0, eff[1], 2'h0, eff[0]};

    // Read mux; reserved bits and unmapped reads give zero.
    assign rd_d = sel_ctrl ? {30'h00000000, ctrl_q} :
        sel_red ? {20'h00000, cfg_q[0]} :
        sel_green ? {20'h00000, cfg_q[1]} :
        sel_status ? status_word : 32'h00000000;

    // Control register write.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_acc && sel_ctrl) begin
            ctrl_q <= pwdata_in[1:0];
        end
    end

    // Red settings write, touching only the red channel.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_q[0] <= CFG_RST;
        end else if (wr_acc && sel_red) begin
            cfg_q[0] <= pwdata_in[CFG_W-1:0];
        end
    end

    // Green settings write, touching only the green channel.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_q[1] <= CFG_RST;
        end else if (wr_acc && sel_green) begin
            cfg_q[1] <= pwdata_in[CFG_W-1:0];
        end
    end

    // Read data is captured in the setup cycle and held for the access cycle.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_q <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_q <= rd_d;
        end
    end

    assign prdata_out = prdata_q;

    // Slot time base: one pulse per slot at the 256 Hz rate.
    assign base_tick = (base_cnt_q == BW'(SLOT_CYCLES - 1));
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            base_cnt_q <= '0;
        end else if (base_tick) begin
            base_cnt_q <= '0;
        end else begin
            base_cnt_q <= base_cnt_q + BW'(1);
        end
    end

    // Ramp time base: one pulse every ramp step.
    assign ramp_tick = (ramp_cnt_q == RW'(RAMP_CYCLES - 1));
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ramp_cnt_q <= '0;
        end else if (ramp_tick) begin
            ramp_cnt_q <= '0;
        end else begin
            ramp_cnt_q <= ramp_cnt_q + RW'(1);
        end
    end

    // One channel per colour, each fed from its own settings only.
    for (genvar i = 0; i < 2; i++) begin : g_chan
        assign ch_if[i].en = cfg_q[i][CFG_EN_BIT];
        assign ch_if[i].gate = ctrl_q[CTRL_OVRD_BIT] && ctrl_q[CTRL_THERMAL_PERMIT_BIT];
        assign ch_if[i].ramp_en = cfg_q[i][CFG_RAMP_BIT];
        assign ch_if[i].rate = cfg_q[i][CFG_RATE_LSB+:2];
        assign ch_if[i].duty = cfg_q[i][CFG_DUTY_LSB+:6];
        assign ch_if[i].base_tick = base_tick;
        assign ch_if[i].ramp_tick = ramp_tick;
        assign eff[i] = ch_if[i].eff;
        assign sink[i] = ch_if[i].sink;
        lpd_led_channel u_chan (
            .sys_clk_in(sys_clk_in),
            .rst_in(rst_in),
            .ch(ch_if[i])
        );
    end

    // Sink drives and current level codes to the analog sinks.
    assign red_led_sink_out = sink[0];
    assign green_led_sink_out = sink[1];
    assign red_led_current_level_out = cfg_q[0][CFG_LEVEL_LSB+:2];
    assign green_led_current_level_out = cfg_q[1][CFG_LEVEL_LSB+:2];

    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // A write access to the red settings register.
    sequence s_red_wr;
        wr_acc && sel_red;
    endsequence

    AST_RED_ONLY: assert property (s_red_wr |=> $stable(cfg_q[1]))
        else $error("Red write changed green settings.");
    AST_GREEN_ONLY: assert property (wr_acc && sel_green |=> $stable(cfg_q[0]))
        else $error("Green write changed red settings.");
    AST_LEVEL_WR: assert property (s_red_wr |=>
        red_led_current_level_out == $past(pwdata_in[CFG_LEVEL_LSB+:2]))
        else $error("Red level did not follow the write.");
    AST_OVRD_OFF: assert property (!ctrl_q[CTRL_OVRD_BIT] |=>
        !red_led_sink_out && !green_led_sink_out)
        else $error("Sink on without override.");
    AST_BASE_PERIOD: assert property (base_tick |=> !base_tick [*8])
        else $error("Slot ticks too close.");
    AST_RD_DATA: assert property (rd_setup && sel_ctrl |=>
        prdata_out == {30'h00000000, $past(ctrl_q)})
        else $error("Control read data wrong.");

endmodule // lpd_led_driver

// [tb/tb_lpd_led_driver.sv]
// Self-checking testbench for the two-channel LED PWM driver.
`timescale 1ns/1ns
module tb_lpd_led_driver;
    import lpd_pkg::*;
    // Short ramp step so a full sweep fits in a brief run.
    localparam int unsigned RAMP_SIM = 20;
    // One table row: control, both channel settings and the status they should give.
    typedef struct packed {
        logic [1:0] ctrl;
        logic [11:0] red;
        logic [11:0] grn;
        logic [31:0] stat;
    } lpd_tb_row_type;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ADDR_W-1:0] paddr_in = '0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [31:0] pwdata_in = '0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic red_led_sink_out;
    logic green_led_sink_out;
    logic [1:0] red_led_current_level_out;
    logic [1:0] green_led_current_level_out;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic err;
    int hi;
    lpd_tb_row_type rows [7] = '{
        '{2'h3, 12'h820, 12'h040, 32'h0001_0020},
        '{2'h3, 12'h86A, 12'h005, 32'h0001_0520},
        '{2'h1, 12'hAA0, 12'h83F, 32'h0000_2020},
        '{2'h2, 12'h8E0, 12'hBFF, 32'h0000_2020},
        '{2'h3, 12'h020, 12'hB3F, 32'h0002_2020},
        '{2'h3, 12'h800, 12'hABF, 32'h0002_2000},
        '{2'h3, 12'h5DF, 12'h000, 32'h0000_001F}
    };

    // The design under test, with a shortened ramp step.
    lpd_led_driver #(.RAMP_CYCLES(RAMP_SIM)) lpd_led_driver_inst (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .paddr_in(paddr_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .red_led_sink_out(red_led_sink_out),
        .green_led_sink_out(green_led_sink_out),
        .red_led_current_level_out(red_led_current_level_out),
        .green_led_current_level_out(green_led_current_level_out)
    );

    // The clock toggles every half period of 50 ns.
    always #50 sys_clk_in = ~sys_clk_in;

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compares one word and counts the outcome.
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares one single-bit output and counts the outcome.
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high at an edge.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        paddr_in <= a;
        pwrite_in <= w;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (pready_out !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t bus answer never came", $time);
            report_and_stop();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        pwrite_in <= 1'b0;
    endtask

    // Checks the LED outputs and every register against its reset value.
    task automatic chk_reset();
        chk_word({30'h0, red_led_current_level_out}, 32'h1);
        chk_word({30'h0, green_led_current_level_out}, 32'h1);
        chk_bit(red_led_sink_out, 1'b0);
        chk_bit(green_led_sink_out, 1'b0);
        apb(ADDR_RED, 1'b0, 32'h0);
        chk_word(rd, 32'h040);
        apb(ADDR_GREEN, 1'b0, 32'h0);
        chk_word(rd, 32'h040);
        apb(ADDR_CTRL, 1'b0, 32'h0);
        chk_word(rd, 32'h0);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        chk_word(rd, 32'h0);
    endtask

    // Main sequence: reset, table of gating cases, then the awkward cases.
    initial begin
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        chk_reset();
        for (int i = 0; i < 7; i++) begin
            apb(ADDR_CTRL, 1'b1, {30'h0, rows[i].ctrl});
            apb(ADDR_RED, 1'b1, {20'h0, rows[i].red});
            apb(ADDR_GREEN, 1'b1, {20'h0, rows[i].grn});
            repeat (3) @(posedge sys_clk_in);
            chk_bit(red_led_sink_out, rows[i].stat[16]);
            chk_bit(green_led_sink_out, rows[i].stat[17]);
            chk_word({30'h0, red_led_current_level_out}, rows[i].red[7:6]);
            chk_word({30'h0, green_led_current_level_out}, rows[i].grn[7:6]);
            apb(ADDR_STATUS, 1'b0, 32'h0);
            chk_word(rd, rows[i].stat);
        end
        // Reserved bits read back as zero; an unmapped place is refused.
        apb(ADDR_CTRL, 1'b1, 32'hFFFF_FFFF);
        apb(ADDR_CTRL, 1'b0, 32'h0);
        chk_word(rd, 32'h3);
        chk_bit(err, 1'b0);
        apb(12'h010, 1'b0, 32'h0);
        chk_word(rd, 32'h0);
        chk_bit(err, 1'b1);
        // Half duty at 256 Hz: count on cycles over exactly one period.
        apb(ADDR_RED, 1'b1, 32'h810);
        repeat (4) @(posedge sys_clk_in);
        hi = 0;
        for (int c = 0; c < SLOTS * SLOT_CYCLES; c++) begin
            @(posedge sys_clk_in);
            if (red_led_sink_out === 1'b1) begin
                hi++;
            end
        end
        chk_word(hi, 16 * SLOT_CYCLES);
        // Ramp from zero to eight, one step per ramp tick, stopping at target.
        apb(ADDR_RED, 1'b1, 32'h800);
        apb(ADDR_RED, 1'b1, 32'hC08);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        rd2 = rd;
        chk_bit(rd2[5:0] <= 6'h01, 1'b1);
        repeat (17) @(posedge sys_clk_in);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        chk_word({26'h0, rd[5:0]}, {26'h0, rd2[5:0]} + 1);
        repeat (200) @(posedge sys_clk_in);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        chk_word({26'h0, rd[5:0]}, 32'h8);
        // Redirect a rising ramp downward part way through.
        apb(ADDR_RED, 1'b1, 32'hC1F);
        repeat (60) @(posedge sys_clk_in);
        apb(ADDR_RED, 1'b1, 32'hC04);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        chk_bit(rd[5:0] > 6'h08, 1'b1);
        repeat (400) @(posedge sys_clk_in);
        apb(ADDR_CTRL, 1'b1, 32'h0);
        apb(ADDR_STATUS, 1'b1, 32'hFFFF_FFFF);
        chk_bit(err, 1'b0);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        chk_word(rd, 32'h0000_0004);
        // Ramp enable at a slow rate applies the duty at once.
        apb(ADDR_RED, 1'b1, 32'hD1E);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        chk_word({26'h0, rd[5:0]}, 32'h1E);
        // A second reset in mid-run restores every reset value.
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        chk_reset();
        report_and_stop();
    end
endmodule // tb_lpd_led_driver
